// File: src/sli_pkg.sv
package sli_pkg;

  // Register port geometry.
  localparam int SLI_ADDR_W = 4;
  localparam int SLI_DATA_W = 16;

  // Register byte addresses.
  localparam logic [3:0] SLI_RXCSR_ADDR = 4'h0;
  localparam logic [3:0] SLI_TXCSR_ADDR = 4'h4;

  // Field positions in the receiver and transmitter control/status registers.
  localparam int SLI_RX_DONE_BIT   = 7;
  localparam int SLI_RX_IE_BIT     = 6;
  localparam int SLI_MODEM_IE_BIT  = 5;
  localparam int SLI_MODEM_EVT_BIT = 15;
  localparam int SLI_TX_RDY_BIT    = 7;
  localparam int SLI_TX_IE_BIT     = 6;
  localparam int SLI_PROG_RATE_BIT = 11;
  localparam int SLI_RATE_LSB      = 12;
  localparam int SLI_RATE_MSB      = 15;

  // Host vector layout.
  localparam int SLI_VEC_LSB    = 3;
  localparam int SLI_VEC_MSB    = 8;
  localparam int SLI_VEC2ND_BIT = 2;

  // Values after reset.
  localparam logic [15:0] SLI_RDATA_RST = 16'h0000;
  localparam logic [3:0]  SLI_RATE_RST  = 4'h0;
  localparam logic [12:0] SLI_CNT_RST   = 13'h0000;

  // Rate code that selects 110 baud.
  localparam logic [3:0] SLI_RATE_CODE_110 = 4'h2;

  // Oscillator ticks per 16x bit clock period, indexed by rate code.
  localparam logic [15:0][12:0] SLI_DIV_TABLE = {
    13'h0010, 13'h0021, 13'h002C, 13'h0042, 13'h0058, 13'h0084, 13'h009E, 13'h00B0,
    13'h0108, 13'h0210, 13'h0420, 13'h0840, 13'h0933, 13'h0B40, 13'h1080, 13'h18C0
  };

  typedef enum logic [3:0] {
    SLI_ST_IDLE = 4'h1,
    SLI_ST_REQ  = 4'h2,
    SLI_ST_VEC  = 4'h4,
    SLI_ST_END  = 4'h8
  } sli_state_t;

endpackage

// File: src/sli_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sli_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Levels in and out.
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// File: src/sli_rate_div.sv
`timescale 1ns/1ps
`default_nettype none
module sli_rate_div (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Oscillator tick and divisor selection.
  input  wire logic       oscTick,
  input  wire logic [3:0] rateCode,
  // Divided 16x bit clock.
  output logic            bitClk
);
  import sli_pkg::*;

  logic [12:0] cnt_q;
  wire  [12:0] divisor  = SLI_DIV_TABLE[rateCode];
  wire  [12:0] lastCnt  = divisor - 13'h0001;
  wire         wrap     = cnt_q >= lastCnt;
  wire         firstHalf = cnt_q < (divisor >> 1);

  // A change to a code whose last count is at or below the count wraps on the next tick, so no count is stranded.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q  <= SLI_CNT_RST;
      bitClk <= 1'b0;
    end else if (oscTick) begin
      cnt_q  <= wrap ? SLI_CNT_RST : cnt_q + 13'h0001;
      bitClk <= firstHalf;
    end
  end
endmodule
`default_nettype wire

// File: src/sli_irq_baud.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sli_irq_baud #(
  parameter bit HAS_MODEM = 1'b1
) (
  // Clock and reset.
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  // Register port.
  input  wire logic [sli_pkg::SLI_ADDR_W-1:0] regAddr,
  input  wire logic [sli_pkg::SLI_DATA_W-1:0] regWrData,
  input  wire logic [1:0]                     regByteEn,
  input  wire logic                           regWr,
  input  wire logic                           regRd,
  output logic      [sli_pkg::SLI_DATA_W-1:0] regRdData,
  // Host bus, logical levels with 1 meaning asserted.
  input  wire logic                           bdin,
  input  wire logic                           biaki,
  input  wire logic                           binit,
  input  wire logic                           powerGood,
  output logic                                birq,
  output logic                                brply,
  output logic                                biako,
  output logic      [sli_pkg::SLI_DATA_W-1:0] bdalOut,
  output logic                                bdalOe,
  // Character section status.
  input  wire logic                           rxCharComplete,
  input  wire logic                           txHoldingEmpty,
  input  wire logic                           modemEvent,
  // Straps and oscillator.
  input  wire logic                           oscIn,
  input  wire logic                           splitSpeed,
  input  wire logic [5:0]                     vectorStrap,
  input  wire logic [3:0]                     rxRateStrap,
  input  wire logic [3:0]                     txRateStrap,
  // Bit clocks and format.
  output logic                                rxBitClk,
  output logic                                txBitClk,
  output logic                                twoStopSelect
);
  import sli_pkg::*;

  // Every bus, status, strap and oscillator pin passes two flip-flops before use; the register port does not.
  logic       bdinS;
  logic       biakiS;
  logic       binitS;
  logic       powerGoodS;
  logic       rxDoneS;
  logic       txEmptyS;
  logic       modemEvtS;
  logic       oscS;
  logic       splitS;
  logic [5:0] vectorStrapS;
  logic [3:0] rxRateStrapS;
  logic [3:0] txRateStrapS;

  sli_sync #(.W(23)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn ({bdin, biaki, binit, powerGood, rxCharComplete, txHoldingEmpty, modemEvent,
               oscIn, splitSpeed, vectorStrap, rxRateStrap, txRateStrap}),
    .syncOut ({bdinS, biakiS, binitS, powerGoodS, rxDoneS, txEmptyS, modemEvtS,
               oscS, splitS, vectorStrapS, rxRateStrapS, txRateStrapS})
  );

  // Register decode.
  wire rxHit  = regAddr == SLI_RXCSR_ADDR;
  wire txHit  = regAddr == SLI_TXCSR_ADDR;
  wire rxWrLo = regWr & rxHit & regByteEn[0];
  wire txWrLo = regWr & txHit & regByteEn[0];
  wire txWrHi = regWr & txHit & regByteEn[1];
  wire wrProg = regWrData[SLI_PROG_RATE_BIT];

  logic       rxIe_q;
  logic       modemIe_q;
  logic       txIe_q;
  logic       progRateEnable_q;
  logic [3:0] rateCode_q;

  // Interrupt enables live in the interrupt logic and clear on initialise.
  always_ff @(posedge ref_clk) begin
    if (rst || binitS) begin
      rxIe_q    <= 1'b0;
      modemIe_q <= 1'b0;
      txIe_q    <= 1'b0;
    end else begin
      if (rxWrLo) begin
        rxIe_q    <= regWrData[SLI_RX_IE_BIT];
        modemIe_q <= HAS_MODEM & regWrData[SLI_MODEM_IE_BIT];
      end
      if (txWrLo) begin
        txIe_q <= regWrData[SLI_TX_IE_BIT];
      end
    end
  end

  // Section A source holds until the next high-byte write, its code until one with bit 11 set; both clear while power good is low.
  always_ff @(posedge ref_clk) begin
    if (rst || !powerGoodS) begin
      progRateEnable_q <= 1'b0;
      rateCode_q       <= SLI_RATE_RST;
    end else if (txWrHi) begin
      progRateEnable_q <= wrProg;
      if (wrProg) begin
        rateCode_q <= regWrData[SLI_RATE_MSB:SLI_RATE_LSB];
      end
    end
  end

  // Read data.
  wire [15:0] rxCsrView = {HAS_MODEM & modemEvtS, 7'h00, rxDoneS, rxIe_q, modemIe_q, 5'h00};
  wire [15:0] txCsrView = {rateCode_q, progRateEnable_q, 3'h0, txEmptyS, txIe_q, 6'h00};
  wire [15:0] readMux   = rxHit ? rxCsrView : (txHit ? txCsrView : SLI_RDATA_RST);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= SLI_RDATA_RST;
    end else begin
      regRdData <= regRd ? readMux : SLI_RDATA_RST;
    end
  end

  // Request conditions and pending flags.
  logic       rxCondPrev_q;
  logic       txCondPrev_q;
  logic       rxPend_q;
  logic       txPend_q;
  sli_state_t state_q;
  sli_state_t state_d;

  wire rxCharCond  = rxIe_q & rxDoneS;
  wire modemCond   = HAS_MODEM & modemIe_q & modemEvtS;
  wire rxCond      = rxCharCond | modemCond;
  wire txCond      = txIe_q & txEmptyS;
  wire anyPend     = rxPend_q | txPend_q;
  wire ackSeen     = bdinS & biakiS;
  wire takeAck     = (state_q == SLI_ST_REQ) & ackSeen & anyPend;
  wire serveRx     = takeAck & rxPend_q;
  wire serveTx     = takeAck & ~rxPend_q;
  wire rxSet       = rxCond & ~rxCondPrev_q;
  wire txSet       = txCond & ~txCondPrev_q;
  wire rxPend_d    = rxSet | (rxPend_q & rxCond & ~serveRx);
  wire txPend_d    = txSet | (txPend_q & txCond & ~serveTx);
  wire [15:0] vecWord = {7'h00, vectorStrapS, ~rxPend_q, 2'b00};

  // A new event wins over the clear of the served flag.
  always_ff @(posedge ref_clk) begin
    if (rst || binitS) begin
      rxCondPrev_q <= 1'b0;
      txCondPrev_q <= 1'b0;
      rxPend_q     <= 1'b0;
      txPend_q     <= 1'b0;
    end else begin
      rxCondPrev_q <= rxCond;
      txCondPrev_q <= txCond;
      rxPend_q     <= rxPend_d;
      txPend_q     <= txPend_d;
    end
  end

  // Interrupt transaction sequencing.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SLI_ST_IDLE: begin
        if (anyPend) state_d = SLI_ST_REQ;
      end
      SLI_ST_REQ: begin
        if (!anyPend) begin
          state_d = SLI_ST_IDLE;
        end else if (ackSeen) begin
          state_d = SLI_ST_VEC;
        end
      end
      SLI_ST_VEC: begin
        if (!bdinS) state_d = SLI_ST_END;
      end
      SLI_ST_END: begin
        if (!biakiS) state_d = SLI_ST_IDLE;
      end
    endcase
  end

  logic vecDrive_q;
  logic secondVectorSelect_q;

  always_ff @(posedge ref_clk) begin
    if (rst || binitS) begin
      state_q              <= SLI_ST_IDLE;
      birq                 <= 1'b0;
      vecDrive_q           <= 1'b0;
      secondVectorSelect_q <= 1'b0;
      bdalOut              <= SLI_RDATA_RST;
    end else begin
      state_q    <= state_d;
      birq       <= state_d == SLI_ST_REQ;
      vecDrive_q <= state_d == SLI_ST_VEC;
      if (takeAck) begin
        secondVectorSelect_q <= ~rxPend_q;
        bdalOut              <= vecWord;
      end else if (state_d != SLI_ST_VEC) begin
        secondVectorSelect_q <= 1'b0;
        bdalOut              <= SLI_RDATA_RST;
      end
    end
  end

  assign brply  = vecDrive_q;
  assign bdalOe = vecDrive_q;
  // Acknowledge is passed on only while nothing here is requesting.
  assign biako  = biakiS & (state_q == SLI_ST_IDLE) & ~anyPend;

  // Baud rate generation.
  logic oscPrev_q;
  logic secAClk;
  logic secBClk;
  wire  oscTick  = oscS & ~oscPrev_q;
  wire [3:0] secACode = progRateEnable_q ? rateCode_q : rxRateStrapS;

  sli_rate_div u_sec_a (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .oscTick  (oscTick),
    .rateCode (secACode),
    .bitClk   (secAClk)
  );

  sli_rate_div u_sec_b (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .oscTick  (oscTick),
    .rateCode (txRateStrapS),
    .bitClk   (secBClk)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oscPrev_q     <= 1'b0;
      rxBitClk      <= 1'b0;
      txBitClk      <= 1'b0;
      twoStopSelect <= 1'b0;
    end else begin
      oscPrev_q     <= oscS;
      rxBitClk      <= secAClk;
      txBitClk      <= splitS ? secBClk : secAClk;
      twoStopSelect <= secACode == SLI_RATE_CODE_110;
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_rx_char_req;
    (rxCharCond && !rxCondPrev_q && !binitS) |=> rxPend_q;
  endproperty
  a_rx_char_req: assert property (p_rx_char_req) else $error("receive request not pending");

  property p_modem_req;
    (modemCond && !rxCondPrev_q && !binitS) |=> rxPend_q;
  endproperty
  a_modem_req: assert property (p_modem_req) else $error("modem request not pending");

  property p_no_modem;
    !HAS_MODEM |-> !modemIe_q && !regRdData[SLI_MODEM_EVT_BIT];
  endproperty
  a_no_modem: assert property (p_no_modem) else $error("modem bits present on plain variant");

  property p_tx_req;
    (txCond && !txCondPrev_q && !binitS) |=> txPend_q;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("transmit request not pending");

  property p_tx_view;
    (regRd && txHit) |=> regRdData[SLI_TX_RDY_BIT] == $past(txEmptyS)
                         && regRdData[SLI_TX_IE_BIT] == $past(txIe_q);
  endproperty
  a_tx_view: assert property (p_tx_view) else $error("transmit status read wrong");

  property p_vec_lines;
    $rose(vecDrive_q) |-> bdalOut[SLI_VEC_MSB:SLI_VEC_LSB] == $past(vectorStrapS)
                          && bdalOut[15:9] == 7'h00 && bdalOut[1:0] == 2'b00;
  endproperty
  a_vec_lines: assert property (p_vec_lines) else $error("vector lines wrong");

  property p_second_vec;
    $rose(vecDrive_q) |-> secondVectorSelect_q == !$past(rxPend_q)
                          && bdalOut[SLI_VEC2ND_BIT] == secondVectorSelect_q;
  endproperty
  a_second_vec: assert property (p_second_vec) else $error("second vector select wrong");

  property p_req_start;
    (state_q == SLI_ST_IDLE && anyPend && !binitS) |=> birq;
  endproperty
  a_req_start: assert property (p_req_start) else $error("request line not raised");

  property p_ack_vec;
    (takeAck && !binitS) |=> vecDrive_q && brply && bdalOe && !birq;
  endproperty
  a_ack_vec: assert property (p_ack_vec) else $error("acknowledge not answered");

  property p_end_vec;
    (vecDrive_q && !bdinS) |=> !brply && !bdalOe && !secondVectorSelect_q;
  endproperty
  a_end_vec: assert property (p_end_vec) else $error("vector not released");

  property p_init_clear;
    binitS |=> !rxIe_q && !txIe_q && !rxPend_q && !txPend_q && !birq && !brply;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("initialise left state");

  property p_two_stop;
    (txWrHi && wrProg && regWrData[SLI_RATE_MSB:SLI_RATE_LSB] == SLI_RATE_CODE_110
     && powerGoodS) |=> ##1 twoStopSelect;
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("two stop select missing");

  property p_strap_src;
    (txWrHi && !wrProg) || !powerGoodS |=> !progRateEnable_q;
  endproperty
  a_strap_src: assert property (p_strap_src) else $error("section A not on straps");

  c_rx_vec: cover property (serveRx ##1 vecDrive_q);
  c_tx_vec: cover property (serveTx ##1 vecDrive_q);
  c_both: cover property (rxPend_q && txPend_q && takeAck);
endmodule
`default_nettype wire

// File: verif/sli_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sli_host_model (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Pause before answering a request.
  input  wire logic [3:0]  answerDelay,
  // Host bus.
  input  wire logic        birq,
  input  wire logic        brply,
  input  wire logic [15:0] bdalOut,
  input  wire logic        bdalOe,
  output logic             bdin,
  output logic             biaki,
  // Served vectors.
  output logic [7:0]       servedCount,
  output logic [15:0]      lastVector
);
  int waitCnt;
  initial begin
    bdin = 1'b0;
    biaki = 1'b0;
    servedCount = 8'h00;
    lastVector = 16'h0000;
    forever begin
      @(posedge ref_clk);
      if (!rst && birq) begin
        repeat (answerDelay) @(posedge ref_clk);
        bdin <= 1'b1;
        @(posedge ref_clk);
        biaki <= 1'b1;
        waitCnt = 0;
        // A request withdrawn before the reply must not hang the host.
        do begin
          @(posedge ref_clk);
          waitCnt++;
        end while (!(brply && bdalOe) && waitCnt < 64);
        if (brply) begin
          lastVector <= bdalOut;
          servedCount <= servedCount + 8'h01;
        end
        bdin <= 1'b0;
        repeat (2) @(posedge ref_clk);
        biaki <= 1'b0;
        repeat (8) @(posedge ref_clk);
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_sli_irq_baud.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sli_irq_baud;
  import sli_pkg::*;
  localparam logic [5:0]  VEC_STRAP = 6'h2A;
  localparam logic [15:0] RX_VEC = {7'h00, VEC_STRAP, 3'h0};
  localparam logic [15:0] TX_VEC = RX_VEC | (16'h0001 << SLI_VEC2ND_BIT);
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic [1:0]  regByteEn = 2'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdData;
  logic        bdin, biaki, birq, brply, bdalOe, biako;
  logic        binit = 1'b0;
  logic        powerGood = 1'b1;
  logic [15:0] bdalOut;
  logic        rxCharComplete = 1'b0;
  logic        txHoldingEmpty = 1'b0;
  logic        modemEvent = 1'b0;
  logic        oscIn = 1'b0;
  logic [3:0]  rxRateStrap = 4'h3;
  logic [3:0]  txRateStrap = 4'hE;
  logic        splitSpeed = 1'b1;
  logic [3:0]  answerDelay = 4'h0;
  logic        rxBitClk, txBitClk, twoStopSelect;
  logic [7:0]  servedCount;
  logic [15:0] lastVector, rd, rdPlain, plainRdData;
  int          errCount = 0;
  int          cmpCount = 0;
  int          cycles = 0;
  int          oscEdges = 0;

  always #2.5 ref_clk = ~ref_clk;
  always #98.65 oscIn = ~oscIn;
  always @(posedge oscIn) oscEdges++;

  sli_irq_baud #(.HAS_MODEM(1'b1)) sli_irq_baud_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regByteEn(regByteEn), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .bdin(bdin), .biaki(biaki), .binit(binit), .powerGood(powerGood), .birq(birq),
    .brply(brply), .biako(biako), .bdalOut(bdalOut), .bdalOe(bdalOe),
    .rxCharComplete(rxCharComplete), .txHoldingEmpty(txHoldingEmpty),
    .modemEvent(modemEvent), .oscIn(oscIn), .splitSpeed(splitSpeed), .vectorStrap(VEC_STRAP),
    .rxRateStrap(rxRateStrap), .txRateStrap(txRateStrap), .rxBitClk(rxBitClk),
    .txBitClk(txBitClk), .twoStopSelect(twoStopSelect));

  // Variant without modem control, watched through its read port only.
  sli_irq_baud #(.HAS_MODEM(1'b0)) sli_irq_baud_plain_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regByteEn(regByteEn), .regWr(regWr), .regRd(regRd), .regRdData(plainRdData),
    .bdin(bdin), .biaki(biaki), .binit(binit), .powerGood(powerGood), .birq(),
    .brply(), .biako(), .bdalOut(), .bdalOe(),
    .rxCharComplete(rxCharComplete), .txHoldingEmpty(txHoldingEmpty),
    .modemEvent(modemEvent), .oscIn(oscIn), .splitSpeed(splitSpeed), .vectorStrap(VEC_STRAP),
    .rxRateStrap(rxRateStrap), .txRateStrap(txRateStrap), .rxBitClk(),
    .txBitClk(), .twoStopSelect());

  sli_host_model sli_host_model_inst (
    .ref_clk(ref_clk), .rst(rst), .answerDelay(answerDelay), .birq(birq), .brply(brply),
    .bdalOut(bdalOut), .bdalOe(bdalOe), .bdin(bdin), .biaki(biaki),
    .servedCount(servedCount), .lastVector(lastVector));

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", errCount, cmpCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regByteEn <= be;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    d = regRdData;
    rdPlain = plainRdData;
  endtask

  // Waits for the host to finish the n-th vector, then checks vector and release.
  // The request line must afterwards stand at expReq.
  task automatic expectVector(input logic [7:0] n, input logic [15:0] vec, input logic expReq);
    int k;
    k = 0;
    while (servedCount !== n && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
    chk({8'h00, servedCount}, {8'h00, n});
    chk(lastVector, vec);
    chk({15'h0000, biako}, 16'h0000);
    repeat (8) @(posedge ref_clk);
    chk({13'h0000, birq, brply, bdalOe}, {13'h0000, expReq, 2'b00});
    chk(bdalOut, 16'h0000);
  endtask

  task automatic checkStop(input logic exp);
    repeat (6) @(posedge ref_clk);
    chk({15'h0000, twoStopSelect}, {15'h0000, exp});
  endtask

  // Counts oscillator edges across one bit clock period, skipping the first.
  task automatic clkPeriod(input logic tx, output logic [15:0] n);
    int s;
    repeat (2) begin
      if (tx) @(posedge txBitClk); else @(posedge rxBitClk);
    end
    s = oscEdges;
    if (tx) @(posedge txBitClk); else @(posedge rxBitClk);
    n = 16'(oscEdges - s);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    regRead(SLI_RXCSR_ADDR, rd);
    chk(rd, 16'h0000);
    regRead(4'h8, rd);
    chk(rd, 16'h0000);
    // Transmitter channel.
    regWrite(SLI_TXCSR_ADDR, 16'h0040, 2'h1);
    txHoldingEmpty <= 1'b1;
    expectVector(8'h01, TX_VEC, 1'b0);
    regRead(SLI_TXCSR_ADDR, rd);
    chk(rd & 16'h00FF, 16'h00C0);
    txHoldingEmpty <= 1'b0;
    // Receiver channel, character done.
    regWrite(SLI_RXCSR_ADDR, 16'h0040, 2'h1);
    rxCharComplete <= 1'b1;
    expectVector(8'h02, RX_VEC, 1'b0);
    rxCharComplete <= 1'b0;
    // Receiver channel, modem event alone.
    regWrite(SLI_RXCSR_ADDR, 16'h0020, 2'h1);
    modemEvent <= 1'b1;
    expectVector(8'h03, RX_VEC, 1'b0);
    regRead(SLI_RXCSR_ADDR, rd);
    chk(rd & 16'h80FF, 16'h8020);
    chk(rdPlain & 16'h80FF, 16'h0000);
    modemEvent <= 1'b0;
    // Both channels at once with a slow host.
    answerDelay <= 4'h6;
    regWrite(SLI_RXCSR_ADDR, 16'h0040, 2'h1);
    regWrite(SLI_TXCSR_ADDR, 16'h0040, 2'h1);
    rxCharComplete <= 1'b1;
    txHoldingEmpty <= 1'b1;
    expectVector(8'h04, RX_VEC, 1'b1);
    expectVector(8'h05, TX_VEC, 1'b0);
    rxCharComplete <= 1'b0;
    txHoldingEmpty <= 1'b0;
    // A request withdrawn before the acknowledge lets the acknowledge pass on.
    repeat (4) @(posedge ref_clk);
    txHoldingEmpty <= 1'b1;
    while (birq !== 1'b1) @(posedge ref_clk);
    txHoldingEmpty <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk({15'h0000, biako}, 16'h0001);
    chk({8'h00, servedCount}, 16'h0005);
    repeat (80) @(posedge ref_clk);
    answerDelay <= 4'h0;
    // Bus initialise clears the enables.
    binit <= 1'b1;
    repeat (4) @(posedge ref_clk);
    binit <= 1'b0;
    repeat (4) @(posedge ref_clk);
    regRead(SLI_TXCSR_ADDR, rd);
    chk(rd & 16'h0040, 16'h0000);
    regRead(SLI_RXCSR_ADDR, rd);
    chk(rd & 16'h0060, 16'h0000);
    txHoldingEmpty <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk({15'h0000, birq}, 16'h0000);
    txHoldingEmpty <= 1'b0;
    // Rate source selection.
    checkStop(1'b0);
    regWrite(SLI_TXCSR_ADDR, 16'h2800, 2'h2);
    checkStop(1'b1);
    regWrite(SLI_TXCSR_ADDR, 16'h5000, 2'h2);
    checkStop(1'b0);
    regWrite(SLI_TXCSR_ADDR, 16'h2800, 2'h2);
    regWrite(SLI_TXCSR_ADDR, 16'h0000, 2'h1);
    checkStop(1'b1);
    powerGood <= 1'b0;
    checkStop(1'b0);
    rxRateStrap <= 4'h2;
    checkStop(1'b1);
    powerGood <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Bit clock periods in oscillator ticks.
    regWrite(SLI_TXCSR_ADDR, 16'hF800, 2'h2);
    clkPeriod(1'b0, rd);
    chk(rd, {3'h0, SLI_DIV_TABLE[15]});
    clkPeriod(1'b1, rd);
    chk(rd, {3'h0, SLI_DIV_TABLE[14]});
    splitSpeed <= 1'b0;
    clkPeriod(1'b1, rd);
    chk(rd, {3'h0, SLI_DIV_TABLE[15]});
    complete_run();
  end
endmodule
`default_nettype wire
